// ### core/sli_pkg.sv
// Package for the serial link interrupt block: register map, field positions,
// reset values and the structs that carry lane events and alignment octets.
// Assumes an 8-bit register port driven by the device's serial control logic.
package sli_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [11:0] ADDR_EN_A = 12'h4b8;    // Enables, first register
  localparam logic [11:0] ADDR_EN_B = 12'h4b9;    // Enables, second register
  localparam logic [11:0] ADDR_STA_A = 12'h4ba;   // Status, first register
  localparam logic [11:0] ADDR_STA_B = 12'h4bb;   // Status, second register
  localparam logic [7:0] RST_EN_A = 8'h00;        // Reset value of enables A
  localparam logic [7:0] RST_EN_B = 8'h00;        // Reset value of enables B
  localparam logic [7:0] RST_STA_A = 8'h00;       // Reset value of status A
  localparam logic [7:0] RST_STA_B = 8'h00;       // Reset value of status B
  localparam logic [7:0] MASK_B = 8'h01;          // Only bit 0 exists in the B registers

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions, shared by enables A and status A
  localparam int BIT_BDE = 7;                     // Bad disparity
  localparam int BIT_NIT = 6;                     // Not in table
  localparam int BIT_UEK = 5;                     // Unexpected control character
  localparam int BIT_ILD = 4;                     // Interlane deskew
  localparam int BIT_ILS = 3;                     // Initial lane sync
  localparam int BIT_CKS = 2;                     // Good checksum
  localparam int BIT_FS = 1;                      // Frame sync
  localparam int BIT_CGS = 0;                     // Code group sync
  localparam int BIT_MISMATCH = 0;                // Config mismatch, in the B registers

  ////////////////////////////////////////////////////////////////////////////
  // Alignment sequence layout
  localparam int ILAS_OCTETS = 14;                // Configuration octets per lane
  localparam logic [3:0] IDX_FIRST = 4'h0;        // First octet index
  localparam logic [3:0] IDX_CKS = 4'hd;          // Index of the checksum octet
  localparam logic [2:0] LANE_CHECKED = 3'h0;     // Only this lane is compared

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic bad_disparity;                          // Error pulse
    logic not_in_table;                           // Error pulse
    logic unexpected_control_char;                // Error pulse
    logic interlane_deskew;                       // Event pulse
    logic initial_lane_sync;                      // Event pulse
    logic frame_sync;                             // Event pulse
    logic code_group_sync;                        // Event pulse
  } sli_lane_evt_t;

  typedef struct packed {
    logic vld;                                    // Octet valid
    logic [2:0] lane;                             // Lane the octet came from
    logic [3:0] idx;                              // Octet index 0..13
    logic [7:0] octet;                            // Octet value
  } sli_ilas_t;

  typedef struct packed {
    logic wr;                                     // Write strobe
    logic rd;                                     // Read strobe
    logic [11:0] addr;                            // Register address
    logic [7:0] wdata;                            // Write data
  } sli_reg_req_t;

  typedef struct packed {
    logic [7:0] sum;                              // Running checksum
    logic mism;                                   // Any octet differed so far
    logic lane0;                                  // Sequence came from lane 0
    logic cks_good;                               // Good checksum pulse
    logic cks_done;                               // Checksum evaluated pulse
    logic mismatch;                               // Mismatch pulse
  } sli_chk_state_t;

  typedef struct packed {
    logic [7:0] en_a;                             // Enables A
    logic [7:0] en_b;                             // Enables B
    logic [7:0] sta_a;                            // Sticky status A
    logic [7:0] sta_b;                            // Sticky status B
    logic [7:0] rdata;                            // Read data
    logic irq;                                    // Interrupt request
  } sli_state_t;

endpackage : sli_pkg

// ### core/sli_ilas_check.sv
// Alignment sequence checker: running checksum and comparison against the
// host-programmed configuration octets. Expects one lane's sequence at a time.
module sli_ilas_check (
  input wire logic i_clk_sys,                     // System clock
  input wire logic i_rstn,                        // Async reset, active low
  input wire logic i_ce,                          // Clock enable
  input wire sli_pkg::sli_ilas_t i_ilas,          // Received octet stream
  input wire logic [111:0] i_host_cfg,            // Host octets, octet 0 in low bits
  output logic o_cks_good,                        // Checksum matched, pulse
  output logic o_cks_done,                        // Checksum evaluated, pulse
  output logic o_mismatch                         // Lane 0 config differs, pulse
);

  sli_pkg::sli_chk_state_t st_reg;                // Registered state
  sli_pkg::sli_chk_state_t st_next;               // Next state
  logic [7:0] host_oct [sli_pkg::ILAS_OCTETS];    // Host octets by index
  logic oct_diff;                                 // Current octet differs

  ////////////////////////////////////////////////////////////////////////////
  // Split the host configuration into octets
  genvar g;
  generate
    for (g = 0; g < sli_pkg::ILAS_OCTETS; g++) begin : g_oct
      assign host_oct[g] = i_host_cfg[g*8 +: 8];
    end
  endgenerate

  // Every octet is compared, the checksum octet included
  assign oct_diff = (i_ilas.idx < 4'(sli_pkg::ILAS_OCTETS)) && (i_ilas.octet != host_oct[i_ilas.idx]);

  ////////////////////////////////////////////////////////////////////////////
  // Next state: accumulate, then judge on the checksum octet
  always_comb begin
    st_next = st_reg;
    st_next.cks_good = 1'b0;
    st_next.cks_done = 1'b0;
    st_next.mismatch = 1'b0;
    if (i_ilas.vld) begin
      if (i_ilas.idx == sli_pkg::IDX_FIRST) begin
        // Restart the sequence on octet 0
        st_next.sum = i_ilas.octet;
        st_next.mism = oct_diff;
        st_next.lane0 = (i_ilas.lane == sli_pkg::LANE_CHECKED);
      end else if (i_ilas.idx == sli_pkg::IDX_CKS) begin
        // Received checksum against own sum; host octet 13 only feeds the mismatch
        st_next.cks_good = (st_reg.sum == i_ilas.octet);
        st_next.cks_done = 1'b1;
        st_next.mismatch = st_reg.lane0 && (st_reg.mism || oct_diff);
      end else begin
        // Checksum wraps modulo 256, so the carry is dropped on purpose
        st_next.sum = 8'(st_reg.sum + i_ilas.octet);
        st_next.mism = st_reg.mism || oct_diff;
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_cks_good = st_reg.cks_good;
  assign o_cks_done = st_reg.cks_done;
  assign o_mismatch = st_reg.mismatch;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_cks_link_only: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_ce && i_ilas.vld && i_ilas.idx == sli_pkg::IDX_CKS |=> o_cks_good == ($past(st_reg.sum) == $past(i_ilas.octet)))
    else $error("checksum result does not follow link data");
  a_cks_octet_cmp: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_ce && i_ilas.vld && i_ilas.idx == sli_pkg::IDX_CKS && st_reg.lane0 && oct_diff |=> o_mismatch)
    else $error("checksum octet difference not flagged");
  a_lane0_only: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_mismatch |-> st_reg.lane0)
    else $error("mismatch raised for another lane");

endmodule : sli_ilas_check

// ### core/sli_irq_ctrl.sv
// Interrupt enables and sticky status for the serial link receive side.
// Assumes lane events arrive as one-cycle pulses from logic on i_clk_sys and
// that the serial control port presents one-cycle read and write strobes.
// Limitation: the skip-alignment option is not seen here, so the sync and
// checksum flags keep reporting even when software has chosen to ignore them.
// Reads return the state before the same cycle's write or event.
module sli_irq_ctrl (
  input wire logic i_clk_sys,                     // System clock, 200 MHz
  input wire logic i_rstn,                        // Async reset, active low
  input wire logic i_ce,                          // Clock enable, freezes all state
  input wire sli_pkg::sli_reg_req_t i_reg,        // Register request
  input wire sli_pkg::sli_lane_evt_t i_evt,       // Lane event pulses
  input wire sli_pkg::sli_ilas_t i_ilas,          // Alignment octet stream
  input wire logic [111:0] i_host_cfg,            // Host config octets 0..13
  output logic [7:0] o_reg_rdata,                 // Read data, one cycle after rd
  output logic o_irq                              // Interrupt request, active high
);

  sli_pkg::sli_state_t st_reg;                    // Registered state
  sli_pkg::sli_state_t st_next;                   // Next state
  logic cks_good;                                 // Good checksum pulse
  logic cks_done;                                 // Checksum evaluated pulse
  logic mismatch;                                 // Config mismatch pulse
  logic [7:0] set_a;                              // Set requests, status A
  logic [7:0] set_b;                              // Set requests, status B
  logic [7:0] clr_a;                              // Clear requests, status A
  logic [7:0] clr_b;                              // Clear requests, status B
  logic [7:0] sta_a_new;                          // Status A after this cycle
  logic [7:0] sta_b_new;                          // Status B after this cycle

  ////////////////////////////////////////////////////////////////////////////
  // Alignment sequence checker
  sli_ilas_check u_chk (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_ilas(i_ilas),
    .i_host_cfg(i_host_cfg),
    .o_cks_good(cks_good),
    .o_cks_done(cks_done),
    .o_mismatch(mismatch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event to flag mapping
  // Events come from logic on this clock, so no synchroniser is placed here;
  // a pin-level source would need one in front of this block.
  // Each pulse asks for its own flag bit; unused bits stay zero.
  always_comb begin
    set_a = 8'h00;
    set_a[sli_pkg::BIT_BDE] = i_evt.bad_disparity;
    set_a[sli_pkg::BIT_NIT] = i_evt.not_in_table;
    set_a[sli_pkg::BIT_UEK] = i_evt.unexpected_control_char;
    set_a[sli_pkg::BIT_ILD] = i_evt.interlane_deskew;
    set_a[sli_pkg::BIT_ILS] = i_evt.initial_lane_sync;
    set_a[sli_pkg::BIT_CKS] = cks_good;
    set_a[sli_pkg::BIT_FS] = i_evt.frame_sync;
    set_a[sli_pkg::BIT_CGS] = i_evt.code_group_sync;
    set_b = 8'h00;
    set_b[sli_pkg::BIT_MISMATCH] = mismatch;
  end

  // Write-one-to-clear; a set in the same cycle wins so no event is lost
  // Writing zero to a bit leaves it alone, so software can clear one flag
  // without a read-modify-write race against new events.
  assign clr_a = (i_reg.wr && i_reg.addr == sli_pkg::ADDR_STA_A) ? i_reg.wdata : 8'h00;
  assign clr_b = (i_reg.wr && i_reg.addr == sli_pkg::ADDR_STA_B) ? (i_reg.wdata & sli_pkg::MASK_B) : 8'h00;
  assign sta_a_new = (st_reg.sta_a & ~clr_a) | set_a;
  assign sta_b_new = (st_reg.sta_b & ~clr_b) | set_b;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register writes, flags, read data and request
  // Only the enable registers are plain storage; status takes its value from
  // the set and clear terms above whatever the bus does.
  always_comb begin
    st_next = st_reg;
    st_next.sta_a = sta_a_new;
    st_next.sta_b = sta_b_new;
    if (i_reg.wr) begin
      unique case (i_reg.addr)
        sli_pkg::ADDR_EN_A: begin
          st_next.en_a = i_reg.wdata;
        end
        sli_pkg::ADDR_EN_B: begin
          st_next.en_b = i_reg.wdata & sli_pkg::MASK_B;
        end
        default: begin
          // Status writes handled above; other addresses ignored
        end
      endcase
    end
    if (i_reg.rd) begin
      // Reads show the state before this cycle's update; unmapped reads zero
      unique case (i_reg.addr)
        sli_pkg::ADDR_EN_A: begin
          st_next.rdata = st_reg.en_a;
        end
        sli_pkg::ADDR_EN_B: begin
          st_next.rdata = st_reg.en_b;
        end
        sli_pkg::ADDR_STA_A: begin
          st_next.rdata = st_reg.sta_a;
        end
        sli_pkg::ADDR_STA_B: begin
          st_next.rdata = st_reg.sta_b;
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end
    // Request from the flags as they stand after this cycle, disabled ones masked
    st_next.irq = |(sta_a_new & st_next.en_a) | |(sta_b_new & st_next.en_b);
  end

  // State register; every register comes out of reset as all zeros
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg.en_a <= sli_pkg::RST_EN_A;
      st_reg.en_b <= sli_pkg::RST_EN_B;
      st_reg.sta_a <= sli_pkg::RST_STA_A;
      st_reg.sta_b <= sli_pkg::RST_STA_B;
      st_reg.rdata <= 8'h00;
      st_reg.irq <= 1'b0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // Both outputs come straight from the state register
  assign o_reg_rdata = st_reg.rdata;
  assign o_irq = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  a_enable_write: assert property (
    i_ce && i_reg.wr && i_reg.addr == sli_pkg::ADDR_EN_A |=> st_reg.en_a == $past(i_reg.wdata))
    else $error("enable A write not stored");
  a_flag_sticky: assert property (
    i_ce && st_reg.sta_a[sli_pkg::BIT_CKS] && !clr_a[sli_pkg::BIT_CKS] |=> st_reg.sta_a[sli_pkg::BIT_CKS])
    else $error("checksum flag dropped without a clear");
  a_clear_one: assert property (
    i_ce && i_reg.wr && i_reg.addr == sli_pkg::ADDR_STA_A && set_a == 8'h00
    |=> st_reg.sta_a == ($past(st_reg.sta_a) & ~$past(i_reg.wdata)))
    else $error("write-one-to-clear wrong");
  a_set_wins: assert property (
    i_ce && cks_good |=> st_reg.sta_a[sli_pkg::BIT_CKS])
    else $error("good checksum did not set its flag");
  a_mismatch_flag: assert property (
    i_ce && mismatch |=> st_reg.sta_b[sli_pkg::BIT_MISMATCH])
    else $error("mismatch flag not held");
  a_irq_gate: assert property (
    i_ce && st_reg.en_a == 8'h00 && st_reg.en_b == 8'h00 && !(i_reg.wr && i_reg.addr[11:1] == 11'h25c) |=> !o_irq)
    else $error("request raised with all sources disabled");
  a_irq_follow: assert property (
    i_ce && st_reg.en_a[sli_pkg::BIT_CKS] && cks_good && !i_reg.wr |=> o_irq)
    else $error("enabled checksum event gave no request");
  a_status_read: assert property (
    i_ce && i_reg.rd && i_reg.addr == sli_pkg::ADDR_STA_A |=> o_reg_rdata == $past(st_reg.sta_a))
    else $error("status A read wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Register port checks
  a_enable_b_write: assert property (
    i_ce && i_reg.wr && i_reg.addr == sli_pkg::ADDR_EN_B
    |=> st_reg.en_b == ($past(i_reg.wdata) & sli_pkg::MASK_B))
    else $error("enable B write not stored");
  a_enable_b_rsvd: assert property (
    st_reg.en_b[7:1] == 7'h00)
    else $error("reserved enable B bits set");
  a_unmapped_read: assert property (
    i_ce && i_reg.rd && i_reg.addr[11:2] != 10'h12e |=> o_reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_rdata_hold: assert property (
    i_ce && !i_reg.rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");
  a_freeze_state: assert property (
    !i_ce |=> st_reg == $past(st_reg))
    else $error("state moved while clock enable low");

  // Flag checks
  a_event_sets: assert property (
    i_ce && set_a != 8'h00 |=> (st_reg.sta_a & $past(set_a)) == $past(set_a))
    else $error("event did not set its flag");
  a_write_zero: assert property (
    i_ce && i_reg.wr && i_reg.addr == sli_pkg::ADDR_STA_A && i_reg.wdata == 8'h00
    |=> st_reg.sta_a == ($past(st_reg.sta_a) | $past(set_a)))
    else $error("write of zero changed status A");
  a_clear_b: assert property (
    i_ce && i_reg.wr && i_reg.addr == sli_pkg::ADDR_STA_B && !mismatch
    |=> st_reg.sta_b == ($past(st_reg.sta_b) & ~($past(i_reg.wdata) & sli_pkg::MASK_B)))
    else $error("status B write-one-to-clear wrong");
  a_status_b_rsvd: assert property (
    st_reg.sta_b[7:1] == 7'h00)
    else $error("reserved status B bits set");

  // Request checks
  a_irq_exact: assert property (
    o_irq == (|(st_reg.sta_a & st_reg.en_a) || |(st_reg.sta_b & st_reg.en_b)))
    else $error("request does not match enabled flags");

  c_irq_rise: cover property (i_ce && !o_irq ##1 o_irq);
  c_mismatch: cover property (mismatch ##1 st_reg.sta_b[sli_pkg::BIT_MISMATCH]);
  c_cks_bad: cover property (cks_done && !cks_good);
  c_set_clear: cover property (i_ce && cks_good && clr_a[sli_pkg::BIT_CKS]);
  c_irq_fall: cover property (o_irq ##1 !o_irq);

endmodule : sli_irq_ctrl

// ### dv/sli_tx_model.sv
// Behavioural far-end transmitter: plays one lane's alignment octets.
// Assumes the bench calls send() from procedural code between other traffic.
module sli_tx_model (
  input wire logic i_clk_sys,                     // System clock
  output sli_pkg::sli_ilas_t o_ilas               // Octet stream into the receiver
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] oct_q [14];                         // Octets of the current sequence
  logic [2:0] lane_q = 3'h0;                      // Lane the sequence is sent on
  int n = 14;                                     // Next index, 14 means idle

  ////////////////////////////////////////////////////////////////////////////
  // Drive at the falling edge; idle fields toggle so stale data cannot match
  initial o_ilas = '0;
  always @(negedge i_clk_sys) begin
    if (n < 14) begin
      o_ilas <= '{vld: 1'b1, lane: lane_q, idx: 4'(n), octet: oct_q[n]};
      n <= n + 1;
    end else begin
      o_ilas <= '{vld: 1'b0, lane: ~o_ilas.lane, idx: ~o_ilas.idx, octet: ~o_ilas.octet};
    end
  end

  // Load 13 body octets, append checksum (optionally corrupted), then play
  task automatic send(input logic [2:0] lane, input logic [103:0] body, input logic bad);
    logic [7:0] sum;
    int k;
    sum = 8'h00;
    for (k = 0; k < 13; k++) begin
      oct_q[k] = body[8*k +: 8];
      sum = sum + body[8*k +: 8];
    end
    oct_q[13] = sum + {7'h00, bad};
    lane_q = lane;
    @(posedge i_clk_sys);
    n = 0;
    wait (n == 14);
    repeat (3) @(negedge i_clk_sys);
  endtask : send
endmodule : sli_tx_model

// ### dv/sli_irq_ctrl_tb.sv
// Self-checking bench for the serial link interrupt block.
// Assumes the transmitter model file is compiled first; inputs move at falling edges.
module sli_irq_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;                         // 200 MHz clock
  logic i_rstn = 1'b0;                            // Reset, active low
  logic i_ce = 1'b1;                              // Clock enable
  sli_pkg::sli_reg_req_t i_reg = '0;              // Register request
  sli_pkg::sli_lane_evt_t i_evt = '0;             // Lane event pulses
  sli_pkg::sli_ilas_t ilas;                       // From the transmitter model
  logic [111:0] host_cfg = '0;                    // Host-programmed octets
  logic [7:0] o_reg_rdata;                        // Read data
  logic o_irq;                                    // Interrupt request
  int err_total = 0;                              // Mismatches
  int checks = 0;                                 // Comparisons
  int k;                                          // Loop index
  logic [7:0] m;                                  // Status mask of one source

  always #2.5 i_clk_sys = ~i_clk_sys;

  sli_irq_ctrl i_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce), .i_reg(i_reg),
    .i_evt(i_evt), .i_ilas(ilas), .i_host_cfg(host_cfg), .o_reg_rdata(o_reg_rdata), .o_irq(o_irq));
  sli_tx_model i_tx (.i_clk_sys(i_clk_sys), .o_ilas(ilas));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // One-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_reg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clk_sys);
    i_reg.wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data is settled by the following falling edge
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge i_clk_sys);
    i_reg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge i_clk_sys);
    i_reg.rd <= 1'b0;
    check(o_reg_rdata, e);
  endtask : rd

  // Play one alignment sequence; host copy optionally differs in one octet.
  // Status is only read here with the sequence present, never when skipped.
  task automatic ilas_run(input logic [2:0] lane, input logic bad, input int edit,
                          input logic [7:0] ea, input logic [7:0] eb);
    logic [103:0] body;
    logic [7:0] sum;
    int j;
    sum = 8'h00;
    for (j = 0; j < 13; j++) begin
      body[8*j +: 8] = 8'h21 + 8'(j * 37);
      sum = sum + body[8*j +: 8];
    end
    host_cfg = {sum + {7'h00, bad}, body};
    if (edit < 14) begin
      host_cfg[8*edit] = ~host_cfg[8*edit];
    end
    i_tx.send(lane, body, bad);
    rd(sli_pkg::ADDR_STA_A, ea);
    rd(sli_pkg::ADDR_STA_B, eb);
    check({7'h00, o_irq}, {7'h00, eb[0]});
    wr(sli_pkg::ADDR_STA_A, 8'hff);
    wr(sli_pkg::ADDR_STA_B, 8'h01);
  endtask : ilas_run

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    err_total++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(negedge i_clk_sys);
    i_rstn <= 1'b1;
    // Reset values and reserved bits
    rd(sli_pkg::ADDR_EN_A, 8'h00);
    rd(sli_pkg::ADDR_EN_B, 8'h00);
    rd(sli_pkg::ADDR_STA_A, 8'h00);
    rd(sli_pkg::ADDR_STA_B, 8'h00);
    wr(sli_pkg::ADDR_EN_A, 8'ha5);
    rd(sli_pkg::ADDR_EN_A, 8'ha5);
    wr(sli_pkg::ADDR_EN_B, 8'hff);
    rd(sli_pkg::ADDR_EN_B, 8'h01);
    wr(12'h4bc, 8'hff);
    rd(12'h4bc, 8'h00);
    // A write while the clock enable is low must not land
    i_ce <= 1'b0;
    wr(sli_pkg::ADDR_EN_A, 8'h5a);
    i_ce <= 1'b1;
    rd(sli_pkg::ADDR_EN_A, 8'ha5);
    wr(sli_pkg::ADDR_EN_A, 8'h00);
    // Every lane event source: sticky, masked, write-zero kept, write-one cleared
    for (k = 0; k < 7; k++) begin
      m = 8'h01 << ((k >= 2) ? k + 1 : k);
      @(negedge i_clk_sys);
      i_evt <= sli_pkg::sli_lane_evt_t'(7'(1 << k));
      @(negedge i_clk_sys);
      i_evt <= '0;
      rd(sli_pkg::ADDR_STA_A, m);
      check({7'h00, o_irq}, 8'h00);
      wr(sli_pkg::ADDR_EN_A, m);
      @(negedge i_clk_sys);
      check({7'h00, o_irq}, 8'h01);
      wr(sli_pkg::ADDR_STA_A, ~m);
      rd(sli_pkg::ADDR_STA_A, m);
      wr(sli_pkg::ADDR_STA_A, m);
      rd(sli_pkg::ADDR_STA_A, 8'h00);
      check({7'h00, o_irq}, 8'h00);
      wr(sli_pkg::ADDR_EN_A, 8'h00);
    end
    // Alignment sequences with the mismatch source enabled
    wr(sli_pkg::ADDR_EN_B, 8'h01);
    ilas_run(3'h0, 1'b0, 99, 8'h04, 8'h00);
    ilas_run(3'h0, 1'b0, 13, 8'h04, 8'h01);
    ilas_run(3'h0, 1'b1, 99, 8'h00, 8'h00);
    ilas_run(3'h3, 1'b0, 5, 8'h04, 8'h00);
    ilas_run(3'h0, 1'b0, 5, 8'h04, 8'h01);
    final_report();
  end
endmodule : sli_irq_ctrl_tb
